// ==== core/ect_defines.svh ====
// constants for the ecc error tracking and checksum command block
// assumes: included by bare name from files under core/
`ifndef ECT_DEFINES_SVH
`define ECT_DEFINES_SVH

// ----------------------------------------
// opcodes
// ----------------------------------------
`define ECT_OPC_UNIT_RD 8'h19
`define ECT_OPC_CLR 8'h1B
`define ECT_OPC_CRC_CALC 8'h5B
`define ECT_OPC_CRC_SUSP 8'h75
`define ECT_OPC_CRC_RES 8'h7A

// ----------------------------------------
// frame lengths in bits, unit address lsb
// ----------------------------------------
`define ECT_OPC_BITS 6'h08
`define ECT_ADDR_BITS 6'h18
`define ECT_DATA_BITS 6'h08
`define ECT_UNIT_LSB 3

// ----------------------------------------
// field positions
// ----------------------------------------
`define ECT_SR_DBL_POS 4
`define ECT_UB_DBL_POS 3

// ----------------------------------------
// reset and start values, checksum polynomial
// ----------------------------------------
`define ECT_CNT_RST 16'h0000
`define ECT_TRAP_RST 32'h0000_0000
`define ECT_CRC_RST 32'hFFFF_FFFF
`define ECT_CRC_INIT 32'h0000_0000
`define ECT_CRC_POLY 32'h1EDC_6F41

// ----------------------------------------
// register read indices
// ----------------------------------------
`define ECT_IDX_SR 2'h0
`define ECT_IDX_CNT 2'h1
`define ECT_IDX_TRAP 2'h2

`endif

// ==== core/ect_pkg.sv ====
// types shared by the ecc error tracking block
// assumes: compiled before every module under core/
package ect_pkg;
	typedef enum logic [4:0] {
		ECT_IDLE = 5'h01,
		ECT_ADDR = 5'h02,
		ECT_DUMMY = 5'h04,
		ECT_DATA = 5'h08,
		ECT_SKIP = 5'h10
	} ect_state_t;

	typedef enum logic [1:0] {
		ECT_SINGLE = 2'h0,
		ECT_DUAL = 2'h1,
		ECT_QUAD = 2'h2
	} ect_lanes_t;
endpackage

// ==== core/ect_serout.sv ====
// status byte serialiser, msb first over one, two or four lanes
// assumes: shift arrives once per serial beat, same clock as the core
`timescale 1ns/10ps
`include "ect_defines.svh"
module ect_serout (
	// clock and reset
	input wire logic clock,
	input wire logic srst,
	input wire logic ce,
	// control
	input wire logic flush,
	input wire logic load,
	input wire logic [7:0] byte_in,
	input wire logic shift,
	input wire ect_pkg::ect_lanes_t lane_mode,
	// lanes
	output logic [3:0] line_q
);
	logic [7:0] sh_q;

	// ----------------------------------------
	// shifter
	// ----------------------------------------
	// zero fill: bytes past the status byte read as zero
	always_ff @(posedge clock) begin
		if (srst || (ce && flush)) begin
			sh_q <= 8'h00;
		end else if (ce && load) begin
			sh_q <= byte_in;
		end else if (ce && shift) begin
			case (lane_mode)
				ect_pkg::ECT_QUAD: sh_q <= {sh_q[3:0], 4'h0};
				ect_pkg::ECT_DUAL: sh_q <= {sh_q[5:0], 2'h0};
				default: sh_q <= {sh_q[6:0], 1'b0};
			endcase
		end
	end

	// single mode answers on lane 1, the serial output line
	assign line_q = (lane_mode == ect_pkg::ECT_QUAD) ? sh_q[7:4] :
		(lane_mode == ect_pkg::ECT_DUAL) ? {2'h0, sh_q[7:6]} : {2'h0, sh_q[7], 1'b0};
endmodule

// ==== core/ect_tracker.sv ====
// double error flag, saturating counter and first address trap
// assumes: det is a one-cycle pulse per failing unit from the read path
`timescale 1ns/10ps
`include "ect_defines.svh"
module ect_tracker #(
	parameter int CNT_W = 16,
	parameter int ADDR_W = 32
) (
	// clock and reset
	input wire logic clock,
	input wire logic srst,
	input wire logic ce,
	// events
	input wire logic wipe,
	input wire logic clr,
	input wire logic det,
	input wire logic [ADDR_W-1:0] det_addr,
	// state
	output logic flag_q,
	output logic [CNT_W-1:0] count_q,
	output logic [ADDR_W-1:0] trap_q
);
	wire at_max = &count_q;
	wire first_hit = clr || !flag_q;

	// ----------------------------------------
	// tracking state
	// ----------------------------------------
	// a detection in the clear cycle survives as the first one after it
	always_ff @(posedge clock) begin
		if (srst || (ce && wipe)) begin
			flag_q <= 1'b0;
			count_q <= CNT_W'(`ECT_CNT_RST);
			trap_q <= ADDR_W'(`ECT_TRAP_RST);
		end else if (ce && det) begin
			flag_q <= 1'b1;
			count_q <= clr ? CNT_W'(1) : (at_max ? count_q : count_q + CNT_W'(1));
			if (first_hit) begin
				trap_q <= det_addr;
			end
		end else if (ce && clr) begin
			flag_q <= 1'b0;
			count_q <= CNT_W'(`ECT_CNT_RST);
			trap_q <= ADDR_W'(`ECT_TRAP_RST);
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_sat;
		@(posedge clock) disable iff (srst)
		(ce && !wipe && !clr && det && at_max) |=> (&count_q);
	endproperty
	a_sat: assert property (p_sat) else $error("counter left saturation");

	property p_trap_hold;
		@(posedge clock) disable iff (srst)
		(ce && !wipe && !clr && flag_q) |=> $stable(trap_q);
	endproperty
	a_trap_hold: assert property (p_trap_hold) else $error("trap overwritten");

	property p_first;
		@(posedge clock) disable iff (srst)
		(ce && !wipe && det && first_hit) |=> (flag_q && count_q == CNT_W'(1) && trap_q == $past(det_addr));
	endproperty
	a_first: assert property (p_first) else $error("first detection not recorded together");

	property p_wipe;
		@(posedge clock) disable iff (srst)
		(ce && wipe) |=> (!flag_q && count_q == '0 && trap_q == '0);
	endproperty
	a_wipe: assert property (p_wipe) else $error("power down did not clear");

	property p_clr;
		@(posedge clock) disable iff (srst)
		(ce && !wipe && clr && !det) |=> (!flag_q && count_q == '0 && trap_q == '0);
	endproperty
	a_clr: assert property (p_clr) else $error("clear did not clear");
endmodule

// ==== core/ect_core.sv ====
// ecc error tracking and checksum command decode
// assumes: serial front end on the same clock delivers one beat per sck edge
//
// Behaviour
// - two-bit error sets sticky flag until clear
// - 16-bit error counter, zero at reset, readable
// - counter stops at all ones
// - deep power down empties the counter
// - trap keeps only first failing unit address
// - deep power down empties the trap
// - trap and counter read through register read
// - unit status read: 19h, address, dummies, sdr
// - clear command 1Bh, no address, sdr only
// - low three address bits ignored
// - latency dummies then 8-bit status byte
// - host ends frame after the status byte
// - status byte bit 3 flags two-bit error; at zero latency it carries the previous lookup's result
// - clear wipes flag, trap and counter
// - clear ignores the write enable latch
// - checksum covers main array words only
// - decode 5Bh, 75h, 7Ah checksum commands
// - ecc works on 8-byte units
// - checksum uses polynomial 1EDC6F41
`timescale 1ns/10ps
`include "ect_defines.svh"
module ect_core #(
	parameter int CNT_W = 16,
	parameter int ADDR_W = 32
) (
	// clock and reset
	input wire logic clock,
	input wire logic srst,
	input wire logic ce,
	// serial front end
	input wire logic sel_active,
	input wire logic beat_valid,
	input wire logic [3:0] beat_in,
	input wire ect_pkg::ect_lanes_t lane_mode,
	input wire logic ddr_mode,
	input wire logic [3:0] latency_code,
	output logic [3:0] line_out,
	output logic [3:0] line_oe,
	// ecc read path
	input wire logic det_valid,
	input wire logic [ADDR_W-1:0] det_addr,
	input wire logic soft_rst,
	input wire logic deep_power_down,
	// unit check
	output logic unit_chk_req,
	output logic [20:0] unit_addr,
	input wire logic unit_chk_done,
	input wire logic unit_chk_bad,
	// register read
	input wire logic [1:0] reg_idx,
	output logic [31:0] reg_data,
	// checksum
	input wire logic crc_word_valid,
	input wire logic [31:0] crc_word,
	input wire logic crc_word_main,
	output logic crc_calc_go,
	output logic crc_suspend_go,
	output logic crc_resume_go,
	output logic [31:0] crc_value
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [5:0] lane_step(input ect_pkg::ect_lanes_t m);
		case (m)
			ect_pkg::ECT_QUAD: lane_step = 6'h04;
			ect_pkg::ECT_DUAL: lane_step = 6'h02;
			default: lane_step = 6'h01;
		endcase
	endfunction

	function automatic logic [23:0] shift_in(input logic [23:0] sh, input logic [3:0] b,
		input ect_pkg::ect_lanes_t m);
		case (m)
			ect_pkg::ECT_QUAD: shift_in = {sh[19:0], b[3:0]};
			ect_pkg::ECT_DUAL: shift_in = {sh[21:0], b[1:0]};
			default: shift_in = {sh[22:0], b[0]};
		endcase
	endfunction

	function automatic logic [3:0] lane_mask(input ect_pkg::ect_lanes_t m);
		case (m)
			ect_pkg::ECT_QUAD: lane_mask = 4'hF;
			ect_pkg::ECT_DUAL: lane_mask = 4'h3;
			default: lane_mask = 4'h2;
		endcase
	endfunction

	// memory words are taken byte swapped into the checksum
	function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [31:0] w);
		logic [31:0] d;
		logic [31:0] r;
		logic fb;
		d = {w[7:0], w[15:8], w[23:16], w[31:24]};
		r = c;
		for (int i = 31; i >= 0; i--) begin
			fb = r[31] ^ d[i];
			r = {r[30:0], 1'b0} ^ (fb ? `ECT_CRC_POLY : 32'h0000_0000);
		end
		crc_step = r;
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	ect_pkg::ect_state_t state_q;
	ect_pkg::ect_state_t state_d;
	logic [23:0] sh_q;
	logic [5:0] bcnt_q;
	logic [5:0] bcnt_d;
	logic [3:0] dcnt_q;
	logic bad_q;
	logic req_q;
	logic [20:0] unit_addr_q;
	logic [2:0] go_q;
	logic [31:0] crc_q;
	logic [31:0] reg_q;
	logic flag;
	logic [CNT_W-1:0] cnt;
	logic [ADDR_W-1:0] trap;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	wire beat_ok = ce && sel_active && beat_valid;
	wire [5:0] step = lane_step(lane_mode);
	wire [23:0] sh_next = shift_in(sh_q, beat_in, lane_mode);
	wire [5:0] cnt_next = bcnt_q + step;
	wire in_idle = (state_q == ect_pkg::ECT_IDLE);
	wire in_addr = (state_q == ect_pkg::ECT_ADDR);
	wire in_dummy = (state_q == ect_pkg::ECT_DUMMY);
	wire in_data = (state_q == ect_pkg::ECT_DATA);
	wire opc_done = beat_ok && in_idle && (cnt_next == `ECT_OPC_BITS);
	wire [7:0] opc = sh_next[7:0];
	// double data rate frames are not ours: opcodes fall through to skip
	wire sdr_ok = opc_done && !ddr_mode;
	wire is_rd = sdr_ok && (opc == `ECT_OPC_UNIT_RD);
	wire is_clr = sdr_ok && (opc == `ECT_OPC_CLR);
	wire is_calc = sdr_ok && (opc == `ECT_OPC_CRC_CALC);
	wire is_susp = sdr_ok && (opc == `ECT_OPC_CRC_SUSP);
	wire is_res = sdr_ok && (opc == `ECT_OPC_CRC_RES);
	wire addr_done = beat_ok && in_addr && (cnt_next == `ECT_ADDR_BITS);
	wire no_lat = (latency_code == 4'h0);
	wire dummy_fin = beat_ok && in_dummy && ((dcnt_q + 4'h1) == latency_code);
	wire ld = (addr_done && no_lat) || dummy_fin;
	wire data_done = beat_ok && in_data && (cnt_next >= `ECT_DATA_BITS);
	wire bad_now = unit_chk_done ? unit_chk_bad : bad_q;
	wire [7:0] ubyte = 8'(bad_now) << `ECT_UB_DBL_POS;
	wire [31:0] sr_word = 32'(flag) << `ECT_SR_DBL_POS;
	wire [31:0] rd_sel = (reg_idx == `ECT_IDX_SR) ? sr_word :
		(reg_idx == `ECT_IDX_CNT) ? 32'(cnt) :
		(reg_idx == `ECT_IDX_TRAP) ? 32'(trap) : 32'h0000_0000;
	wire wipe = soft_rst || deep_power_down;

	// ----------------------------------------
	// frame sequencer
	// ----------------------------------------
	always_comb begin
		state_d = state_q;
		case (state_q)
			ect_pkg::ECT_IDLE: begin
				if (opc_done) begin
					state_d = is_rd ? ect_pkg::ECT_ADDR : ect_pkg::ECT_SKIP;
				end
			end
			ect_pkg::ECT_ADDR: begin
				if (addr_done) begin
					state_d = no_lat ? ect_pkg::ECT_DATA : ect_pkg::ECT_DUMMY;
				end
			end
			ect_pkg::ECT_DUMMY: begin
				if (dummy_fin) begin
					state_d = ect_pkg::ECT_DATA;
				end
			end
			ect_pkg::ECT_DATA: begin
				// one byte only; later clocks see zero until a new frame
				if (data_done) begin
					state_d = ect_pkg::ECT_SKIP;
				end
			end
			ect_pkg::ECT_SKIP: state_d = ect_pkg::ECT_SKIP;
			default: state_d = ect_pkg::ECT_IDLE;
		endcase
	end

	always_comb begin
		bcnt_d = bcnt_q;
		if (state_d != state_q) begin
			bcnt_d = 6'h00;
		end else if (beat_ok) begin
			bcnt_d = cnt_next;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			state_q <= ect_pkg::ECT_IDLE;
			bcnt_q <= 6'h00;
			sh_q <= 24'h00_0000;
		end else if (ce && !sel_active) begin
			state_q <= ect_pkg::ECT_IDLE;
			bcnt_q <= 6'h00;
			sh_q <= 24'h00_0000;
		end else if (ce) begin
			state_q <= state_d;
			bcnt_q <= bcnt_d;
			if (beat_ok) begin
				sh_q <= sh_next;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			dcnt_q <= 4'h0;
		end else if (ce) begin
			dcnt_q <= (in_dummy && beat_ok) ? dcnt_q + 4'h1 : (in_dummy ? dcnt_q : 4'h0);
		end
	end

	// ----------------------------------------
	// unit status lookup
	// ----------------------------------------
	// the answer must come back before the dummies run out
	always_ff @(posedge clock) begin
		if (srst) begin
			req_q <= 1'b0;
			unit_addr_q <= 21'h00_0000;
			bad_q <= 1'b0;
		end else if (ce) begin
			req_q <= addr_done;
			if (addr_done) begin
				unit_addr_q <= sh_next[23:`ECT_UNIT_LSB];
				bad_q <= 1'b0;
			end else if (unit_chk_done) begin
				bad_q <= unit_chk_bad;
			end
		end
	end

	ect_serout u_ser (
		.clock(clock),
		.srst(srst),
		.ce(ce),
		.flush(!sel_active),
		.load(ld),
		.byte_in(ubyte),
		.shift(beat_ok && in_data),
		.lane_mode(lane_mode),
		.line_q(line_out)
	);

	assign line_oe = (in_data || state_q == ect_pkg::ECT_SKIP) && sel_active &&
		(state_q != ect_pkg::ECT_SKIP || bcnt_q == 6'h00) ? lane_mask(lane_mode) : 4'h0;

	// ----------------------------------------
	// error tracking
	// ----------------------------------------
	// clear needs no write enable, so it is decoded without a write enable gate, in sdr frames only
	ect_tracker #(
		.CNT_W(CNT_W),
		.ADDR_W(ADDR_W)
	) u_trk (
		.clock(clock),
		.srst(srst),
		.ce(ce),
		.wipe(wipe),
		.clr(is_clr),
		.det(det_valid),
		.det_addr(det_addr),
		.flag_q(flag),
		.count_q(cnt),
		.trap_q(trap)
	);

	always_ff @(posedge clock) begin
		if (srst) begin
			reg_q <= 32'h0000_0000;
		end else if (ce) begin
			reg_q <= rd_sel;
		end
	end

	// ----------------------------------------
	// checksum commands and engine
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (srst) begin
			go_q <= 3'h0;
			crc_q <= `ECT_CRC_RST;
		end else if (ce) begin
			go_q <= {is_calc, is_susp, is_res};
			if (is_calc) begin
				crc_q <= `ECT_CRC_INIT;
			end else if (crc_word_valid && crc_word_main) begin
				crc_q <= crc_step(crc_q, crc_word);
			end
		end else begin
			go_q <= 3'h0;
		end
	end

	assign unit_chk_req = req_q;
	assign unit_addr = unit_addr_q;
	assign reg_data = reg_q;
	assign crc_calc_go = go_q[2];
	assign crc_suspend_go = go_q[1];
	assign crc_resume_go = go_q[0];
	assign crc_value = crc_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_unit_addr;
		@(posedge clock) disable iff (srst)
		addr_done |=> (unit_chk_req && unit_addr == $past(sh_next[23:3]));
	endproperty
	a_unit_addr: assert property (p_unit_addr) else $error("unit address wrong");

	property p_dummy;
		@(posedge clock) disable iff (srst)
		ld |=> (state_q == ect_pkg::ECT_DATA && line_out == ((lane_mode == ect_pkg::ECT_QUAD) ? $past(ubyte[7:4]) :
			(lane_mode == ect_pkg::ECT_DUAL) ? {2'h0, $past(ubyte[7:6])} : {2'h0, $past(ubyte[7]), 1'b0}));
	endproperty
	a_dummy: assert property (p_dummy) else $error("status byte not presented after latency");

	property p_ubyte;
		@(posedge clock) disable iff (srst)
		ld |-> ((ubyte & 8'hF7) == 8'h00 && ubyte[3] == bad_now);
	endproperty
	a_ubyte: assert property (p_ubyte) else $error("status byte layout wrong");

	property p_skip;
		@(posedge clock) disable iff (srst)
		data_done |=> (state_q == ect_pkg::ECT_SKIP && line_out == 4'h0);
	endproperty
	a_skip: assert property (p_skip) else $error("data after status byte");

	property p_crc_calc;
		@(posedge clock) disable iff (srst)
		is_calc |=> (crc_calc_go && crc_value == 32'h0000_0000);
	endproperty
	a_crc_calc: assert property (p_crc_calc) else $error("calculate not started");

	property p_ddr;
		@(posedge clock) disable iff (srst)
		(opc_done && ddr_mode) |=> (!crc_calc_go && !crc_suspend_go && !crc_resume_go && !in_addr);
	endproperty
	a_ddr: assert property (p_ddr) else $error("ddr opcode accepted");

	property p_clr_cmd;
		@(posedge clock) disable iff (srst)
		(is_clr && !det_valid) |=> (!flag && cnt == '0 && trap == '0);
	endproperty
	a_clr_cmd: assert property (p_clr_cmd) else $error("clear command ineffective");

	property p_crc_main;
		@(posedge clock) disable iff (srst)
		(ce && crc_word_valid && !crc_word_main && !is_calc) |=> $stable(crc_value);
	endproperty
	a_crc_main: assert property (p_crc_main) else $error("non array word entered checksum");

	property p_reg_read;
		@(posedge clock) disable iff (srst)
		(ce && reg_idx == `ECT_IDX_CNT) |=> (reg_data == 32'($past(cnt)));
	endproperty
	a_reg_read: assert property (p_reg_read) else $error("counter read wrong");

	c_status_read: cover property (@(posedge clock) disable iff (srst) ld ##[1:8] data_done);
	c_clear: cover property (@(posedge clock) disable iff (srst) is_clr);
	c_calc: cover property (@(posedge clock) disable iff (srst) is_calc);
	c_sat: cover property (@(posedge clock) disable iff (srst) det_valid && (&cnt));
endmodule

// ==== test/ect_host_model.sv ====
// host serial controller model driving the front end beat interface
// assumes: same clock as the core; every change lands 1 ns after the rising edge
`timescale 1ns/10ps
module ect_host_model (
	// clock
	input wire logic clock,
	// beat interface
	output logic sel_active,
	output logic beat_valid,
	output logic [3:0] beat_in,
	// lane setup and returned lanes
	input wire ect_pkg::ect_lanes_t lane_mode,
	input wire logic [3:0] line_out
);
	// idle cycles after each beat, zero for a prompt host
	int gap = 0;

	initial begin
		sel_active = 1'b0;
		beat_valid = 1'b0;
		beat_in = 4'h0;
	end

	function automatic int lanes();
		return (lane_mode == ect_pkg::ECT_QUAD) ? 4 : (lane_mode == ect_pkg::ECT_DUAL) ? 2 : 1;
	endfunction

	// --------------------------------
	// beats
	// --------------------------------
	// idle lines show the inverse so stale data never passes for fresh
	task automatic beat(input logic [3:0] v);
		int i;
		sel_active = 1'b1;
		beat_valid = 1'b1;
		beat_in = v;
		@(posedge clock);
		#1;
		if (gap > 0) begin
			beat_valid = 1'b0;
			beat_in = ~v;
		end
		for (i = 0; i < gap; i++) begin
			@(posedge clock);
			#1;
		end
	endtask

	task automatic send(input logic [31:0] val, input int nbits);
		int k;
		int w;
		w = lanes();
		for (k = nbits - w; k >= 0; k -= w) begin
			beat(4'((val >> k) & ((32'h1 << w) - 1)));
		end
	endtask

	// --------------------------------
	// frames
	// --------------------------------
	task automatic frame(input logic [7:0] opc, input logic has_addr, input logic [23:0] addr,
		input int dummies, output logic [7:0] status);
		int k;
		int w;
		logic [3:0] chunk;
		w = lanes();
		status = 8'h00;
		send({24'h0, opc}, 8);
		if (has_addr) begin
			send({8'h0, addr}, 24);
			for (k = 0; k < dummies; k++) begin
				beat(4'hA);
			end
			for (k = 0; k < 8; k += w) begin
				chunk = (w == 1) ? {3'h0, line_out[1]} : (line_out & 4'((32'h1 << w) - 1));
				status = (status << w) | {4'h0, chunk};
				beat(4'h5);
			end
		end
		// select drops after the last beat and its gap cycles, then two clocks pass with select low
		sel_active = 1'b0;
		beat_valid = 1'b0;
		beat_in = ~beat_in;
		@(posedge clock);
		#1;
		@(posedge clock);
		#1;
	endtask
endmodule

// ==== test/test_ecc_error_tracking_and_crc_cmds.sv ====
// self-checking bench for the ecc tracking and checksum command core
// assumes: host model on the beat interface, bench acts as ecc read path and unit checker
`timescale 1ns/10ps
module test_ecc_error_tracking_and_crc_cmds;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic ce = 1'b1;
	logic sel_active;
	logic beat_valid;
	logic [3:0] beat_in;
	ect_pkg::ect_lanes_t lane_mode = ect_pkg::ECT_SINGLE;
	logic ddr_mode = 1'b0;
	logic [3:0] latency_code = 4'h2;
	logic [3:0] line_out;
	logic [3:0] line_oe;
	logic det_valid = 1'b0;
	logic [31:0] det_addr = 32'h0000_0000;
	logic soft_rst = 1'b0;
	logic deep_power_down = 1'b0;
	logic unit_chk_req;
	logic [20:0] unit_addr;
	logic unit_chk_done;
	logic unit_chk_bad;
	logic [1:0] reg_idx = 2'h0;
	logic [31:0] reg_data;
	logic crc_word_valid = 1'b0;
	logic [31:0] crc_word = 32'h0000_0000;
	logic crc_word_main = 1'b0;
	logic crc_calc_go;
	logic crc_suspend_go;
	logic crc_resume_go;
	logic [31:0] crc_value;
	logic [20:0] bad_unit = 21'h00_0000;
	logic [7:0] st;
	logic [7:0] crc_ops [3] = '{8'h5B, 8'h75, 8'h7A};
	int go_n [3] = '{0, 0, 0};
	int oe_n = 0;
	int error_cnt = 0;
	int samples_checked = 0;
	int cyc = 0;
	localparam logic [31:0] A1 = 32'h0000_1238;
	localparam logic [31:0] A2 = 32'h0000_2F40;

	always #5 clock = ~clock;

	ect_core dut_u (.clock(clock), .srst(srst), .ce(ce), .sel_active(sel_active), .beat_valid(beat_valid),
		.beat_in(beat_in), .lane_mode(lane_mode), .ddr_mode(ddr_mode), .latency_code(latency_code),
		.line_out(line_out), .line_oe(line_oe), .det_valid(det_valid), .det_addr(det_addr),
		.soft_rst(soft_rst), .deep_power_down(deep_power_down), .unit_chk_req(unit_chk_req), .unit_addr(unit_addr),
		.unit_chk_done(unit_chk_done), .unit_chk_bad(unit_chk_bad), .reg_idx(reg_idx),
		.reg_data(reg_data), .crc_word_valid(crc_word_valid), .crc_word(crc_word),
		.crc_word_main(crc_word_main), .crc_calc_go(crc_calc_go), .crc_suspend_go(crc_suspend_go),
		.crc_resume_go(crc_resume_go), .crc_value(crc_value));

	ect_host_model host_u (.clock(clock), .sel_active(sel_active), .beat_valid(beat_valid),
		.beat_in(beat_in), .lane_mode(lane_mode), .line_out(line_out));

	// --------------------------------
	// unit checker and monitors
	// --------------------------------
	// answers in the request cycle, so any latency of one or more is safe
	assign unit_chk_done = unit_chk_req;
	assign unit_chk_bad = (unit_addr == bad_unit);

	always @(posedge clock) begin
		go_n[0] <= go_n[0] + int'(crc_calc_go === 1'b1);
		go_n[1] <= go_n[1] + int'(crc_suspend_go === 1'b1);
		go_n[2] <= go_n[2] + int'(crc_resume_go === 1'b1);
		oe_n <= oe_n + int'(line_oe !== 4'h0);
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			error_cnt++;
			complete_run();
		end
	end

	// --------------------------------
	// tasks
	// --------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic rd(input logic [1:0] idx, input logic [31:0] exp);
		reg_idx = idx;
		@(posedge clock);
		#1;
		check(reg_data, exp);
	endtask

	task automatic dets(input logic [31:0] a, input int n);
		det_valid = 1'b1;
		det_addr = a;
		repeat (n) @(posedge clock);
		#1;
		det_valid = 1'b0;
		@(posedge clock);
		#1;
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// --------------------------------
	// tests
	// --------------------------------
	initial begin
		repeat (20) @(posedge clock);
		#1;
		srst = 1'b0;
		rd(2'h0, 32'h0);
		rd(2'h1, 32'h0);
		rd(2'h2, 32'h0);
		$display("test reset finished");
		ce = 1'b0;
		dets(A2, 1);
		ce = 1'b1;
		rd(2'h1, 32'h0);
		dets(A1, 1);
		dets(A2, 1);
		rd(2'h0, 32'h10);
		rd(2'h1, 32'h2);
		rd(2'h2, A1);
		rd(2'h3, 32'h0);
		$display("test tracking finished");
		bad_unit = A1[23:3];
		for (int m = 0; m < 3; m++) begin
			lane_mode = ect_pkg::ect_lanes_t'(m);
			latency_code = 4'(1 + 3 * m);
			host_u.gap = m;
			host_u.frame(8'h19, 1'b1, A1[23:0] | 24'h5, 1 + 3 * m, st);
			check({24'h0, st}, 32'h08);
			check({11'h0, unit_addr}, {11'h0, A1[23:3]});
			host_u.frame(8'h19, 1'b1, A2[23:0] | 24'h7, 1 + 3 * m, st);
			check({24'h0, st}, 32'h00);
		end
		host_u.gap = 0;
		// lanes driven per frame: 8 single, 9 dual, 8 quad, counting idle beats after the byte
		check(32'(oe_n), 32'h32);
		latency_code = 4'h0;
		host_u.frame(8'h19, 1'b1, A2[23:0], 0, st);
		check({24'h0, st}, 32'h00);
		$display("test unit read finished");
		ddr_mode = 1'b1;
		host_u.frame(8'h1B, 1'b0, 24'h0, 0, st);
		ddr_mode = 1'b0;
		rd(2'h1, 32'h2);
		host_u.frame(8'h1B, 1'b0, 24'h0, 0, st);
		rd(2'h0, 32'h0);
		rd(2'h1, 32'h0);
		rd(2'h2, 32'h0);
		dets(A2, 1);
		rd(2'h2, A2);
		$display("test clear finished");
		dets(A1, 65534);
		rd(2'h1, 32'hFFFF);
		dets(A1, 1);
		rd(2'h1, 32'hFFFF);
		rd(2'h2, A2);
		$display("test saturation finished");
		deep_power_down = 1'b1;
		repeat (3) @(posedge clock);
		#1;
		deep_power_down = 1'b0;
		rd(2'h1, 32'h0);
		rd(2'h2, 32'h0);
		dets(A1, 3);
		soft_rst = 1'b1;
		@(posedge clock);
		#1;
		soft_rst = 1'b0;
		rd(2'h1, 32'h0);
		$display("test power down finished");
		lane_mode = ect_pkg::ECT_DUAL;
		for (int k = 0; k < 3; k++) begin
			host_u.frame(crc_ops[k], 1'b0, 24'h0, 0, st);
			check(32'(go_n[k]), 32'h1);
		end
		ddr_mode = 1'b1;
		host_u.frame(8'h5B, 1'b0, 24'h0, 0, st);
		ddr_mode = 1'b0;
		check(32'(go_n[0]), 32'h1);
		check(crc_value, 32'h0);
		crc_word_valid = 1'b1;
		crc_word = 32'hA5A5_0F0F;
		@(posedge clock);
		#1;
		crc_word_valid = 1'b0;
		@(posedge clock);
		#1;
		check(crc_value, 32'h0);
		// swapped word is 1, so one step from zero leaves just the polynomial
		crc_word_valid = 1'b1;
		crc_word_main = 1'b1;
		crc_word = 32'h0100_0000;
		@(posedge clock);
		#1;
		crc_word_valid = 1'b0;
		@(posedge clock);
		#1;
		check(crc_value, 32'h1EDC_6F41);
		$display("test checksum finished");
		complete_run();
	end
endmodule
